//--- logic/gevsf_defines.vh
`ifndef GEVSF_DEFINES_VH
`define GEVSF_DEFINES_VH

// Summary register location: main page, address zero.
`define GEVSF_PAGE_MAIN 1'h0
`define GEVSF_SUMMARY_ADDR 6'h00

// The summary field occupies frame data bits 23 down to 8.
`define GEVSF_FIELD_LSB 8
`define GEVSF_FIELD_WIDTH 16
`define GEVSF_SUMMARY_RESET 16'h0000

// Bit positions of the summary bits, as frame data bit numbers.
`define GEVSF_DIE_TEMP_BIT 23
`define GEVSF_BIAS_UV_BIT 22
`define GEVSF_COMM_ERR_BIT 21
`define GEVSF_WAKE_BIT 20
`define GEVSF_PRE_REG_BIT 19
`define GEVSF_STEP_UP_BIT 18
`define GEVSF_CORE_A_BIT 17
`define GEVSF_CORE_B_BIT 16
`define GEVSF_AUX_BIT 15
`define GEVSF_LIN_A_BIT 14
`define GEVSF_LIN_B_BIT 13
`define GEVSF_LIN_C_BIT 12
`define GEVSF_HV_LIN_BIT 11
`define GEVSF_STBY_TMR_BIT 10
`define GEVSF_SUPPLY_UV_BIT 9
`define GEVSF_THERM_ST_BIT 8

`endif

//--- logic/gevsf_or_group.v
`timescale 1ns/1ps

// One summary bit: the OR of a group of individual event flags.
// It holds no state, so the bit drops as soon as the last flag clears.
module gevsf_or_group #(
  parameter N = 2
) (
  // Individual flags of the group.
  input wire [N-1:0] flags,
  // Combined event.
  output wire any_flag
);

  // Reduction OR keeps the cell width independent.
  assign any_flag = |flags;

endmodule // gevsf_or_group

//--- logic/gevsf_summary_reg.v
`timescale 1ns/1ps
`include "gevsf_defines.vh"

module gevsf_summary_reg (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Register access port.
  input wire reg_page,
  input wire [5:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  // Die temperature and bias regulator flags.
  input wire die_temp_event_flag,
  input wire bias_reg_uv_high_flag,
  // Communication error flags of the main page.
  input wire comm_crc_err_flag,
  input wire comm_req_err_flag,
  // Wake-up input flags.
  input wire wake_input_a,
  input wire wake_input_b,
  // Pre-regulator flags.
  input wire pre_regulator_oc_flag,
  input wire pre_regulator_uv_high_flag,
  input wire pre_regulator_uv_low_flag,
  input wire pre_regulator_feedback_ov_flag,
  // Step-up converter flags.
  input wire step_up_ot_flag,
  input wire step_up_ov_flag,
  // Core step-down converter flags.
  input wire core_stepdown_a_oc_flag,
  input wire core_stepdown_a_ot_flag,
  input wire core_stepdown_b_oc_flag,
  input wire core_stepdown_b_ot_flag,
  // Auxiliary step-down converter flags.
  input wire aux_stepdown_oc_flag,
  input wire aux_stepdown_ot_flag,
  // Linear regulator flags.
  input wire linear_reg_a_oc_flag,
  input wire linear_reg_a_ot_flag,
  input wire linear_reg_b_oc_flag,
  input wire linear_reg_b_ot_flag,
  input wire linear_reg_c_oc_flag,
  input wire linear_reg_c_ot_flag,
  // High-voltage linear regulator flags.
  input wire hv_linear_oc_flag,
  input wire hv_linear_ot_flag,
  input wire hv_linear_input_uv_flag,
  // Standby timer flag.
  input wire standby_timer_expiry_flag,
  // Supply undervoltage flags.
  input wire supply_uv_high_flag,
  input wire supply_uv_low_flag,
  input wire supply_uv7_flag,
  // Thermal shutdown self-test flag.
  input wire thermal_selftest_error_flag,
  // Read answer.
  output reg [15:0] reg_rdata_q,
  output reg reg_rvalid_q,
  // Write that was dropped on the read-only register.
  output reg reg_wr_ignored_q,
  // Live copy of the summary for the rest of the device.
  output reg [15:0] summary_q
);

  // Combinational summary, one bit per group.
  wire [15:0] summary_d;
  wire reg_hit;
  wire rd_hit;
  wire wr_hit;

  // Group events for the temperature, bias, link and wake bits.
  wire die_temp_summary;
  wire bias_reg_uv_summary;
  wire comm_error_summary;
  wire wake_summary;

  // Group events for the switching converters.
  wire pre_regulator_summary;
  wire step_up_summary;
  wire core_stepdown_a_summary;
  wire core_stepdown_b_summary;
  wire aux_stepdown_summary;

  // Group events for the linear regulators.
  wire linear_reg_a_summary;
  wire linear_reg_b_summary;
  wire linear_reg_c_summary;
  wire hv_linear_reg_summary;

  // Group events for the timer, the supply and the thermal self-test.
  wire standby_timer_summary;
  wire supply_uv_summary;
  wire thermal_selftest_summary;

  // Die temperature summary has a single source.
  gevsf_or_group #(.N(1)) u_die_temp (
    .flags(die_temp_event_flag),
    .any_flag(die_temp_summary)
  );

  // Bias regulator summary follows the high undervoltage flag only.
  gevsf_or_group #(.N(1)) u_bias_uv (
    .flags(bias_reg_uv_high_flag),
    .any_flag(bias_reg_uv_summary)
  );

  // Communication error summary covers CRC and request errors.
  gevsf_or_group #(.N(2)) u_comm_err (
    .flags({comm_crc_err_flag, comm_req_err_flag}),
    .any_flag(comm_error_summary)
  );

  // Wake summary covers both wake inputs.
  gevsf_or_group #(.N(2)) u_wake (
    .flags({wake_input_a, wake_input_b}),
    .any_flag(wake_summary)
  );

  // Pre-regulator summary covers its four fault flags.
  gevsf_or_group #(.N(4)) u_pre_reg (
    .flags({pre_regulator_oc_flag, pre_regulator_uv_high_flag,
      pre_regulator_uv_low_flag, pre_regulator_feedback_ov_flag}),
    .any_flag(pre_regulator_summary)
  );

  // Step-up converter summary.
  gevsf_or_group #(.N(2)) u_step_up (
    .flags({step_up_ot_flag, step_up_ov_flag}),
    .any_flag(step_up_summary)
  );

  // First core step-down converter summary.
  gevsf_or_group #(.N(2)) u_core_a (
    .flags({core_stepdown_a_oc_flag, core_stepdown_a_ot_flag}),
    .any_flag(core_stepdown_a_summary)
  );

  // Second core step-down converter summary.
  gevsf_or_group #(.N(2)) u_core_b (
    .flags({core_stepdown_b_oc_flag, core_stepdown_b_ot_flag}),
    .any_flag(core_stepdown_b_summary)
  );

  // Auxiliary step-down converter summary.
  gevsf_or_group #(.N(2)) u_aux (
    .flags({aux_stepdown_oc_flag, aux_stepdown_ot_flag}),
    .any_flag(aux_stepdown_summary)
  );

  // Linear regulator summaries, one per regulator, in bit order.
  gevsf_or_group #(.N(2)) u_lin_a (
    .flags({linear_reg_a_oc_flag, linear_reg_a_ot_flag}),
    .any_flag(linear_reg_a_summary)
  );

  gevsf_or_group #(.N(2)) u_lin_b (
    .flags({linear_reg_b_oc_flag, linear_reg_b_ot_flag}),
    .any_flag(linear_reg_b_summary)
  );

  gevsf_or_group #(.N(2)) u_lin_c (
    .flags({linear_reg_c_oc_flag, linear_reg_c_ot_flag}),
    .any_flag(linear_reg_c_summary)
  );

  // High-voltage regulator summary includes its input undervoltage.
  gevsf_or_group #(.N(3)) u_hv_lin (
    .flags({hv_linear_oc_flag, hv_linear_ot_flag,
      hv_linear_input_uv_flag}),
    .any_flag(hv_linear_reg_summary)
  );

  // Standby timer summary has a single source.
  gevsf_or_group #(.N(1)) u_stby_tmr (
    .flags(standby_timer_expiry_flag),
    .any_flag(standby_timer_summary)
  );

  // Supply undervoltage summary covers all three thresholds.
  gevsf_or_group #(.N(3)) u_supply_uv (
    .flags({supply_uv_high_flag, supply_uv_low_flag, supply_uv7_flag}),
    .any_flag(supply_uv_summary)
  );

  // Thermal shutdown self-test summary has a single source.
  gevsf_or_group #(.N(1)) u_therm_st (
    .flags(thermal_selftest_error_flag),
    .any_flag(thermal_selftest_summary)
  );

  // Place each group event on its bit of the field. The frame bit numbers
  // are rebased on the field's low bit, so frame bit 23 is word bit 15 and
  // frame bit 8 is word bit 0.
  // Temperature, bias, link error and wake bits.
  assign summary_d[`GEVSF_DIE_TEMP_BIT-`GEVSF_FIELD_LSB] =
    die_temp_summary;
  assign summary_d[`GEVSF_BIAS_UV_BIT-`GEVSF_FIELD_LSB] =
    bias_reg_uv_summary;
  assign summary_d[`GEVSF_COMM_ERR_BIT-`GEVSF_FIELD_LSB] =
    comm_error_summary;
  assign summary_d[`GEVSF_WAKE_BIT-`GEVSF_FIELD_LSB] =
    wake_summary;

  // Switching converter bits.
  assign summary_d[`GEVSF_PRE_REG_BIT-`GEVSF_FIELD_LSB] =
    pre_regulator_summary;
  assign summary_d[`GEVSF_STEP_UP_BIT-`GEVSF_FIELD_LSB] =
    step_up_summary;
  assign summary_d[`GEVSF_CORE_A_BIT-`GEVSF_FIELD_LSB] =
    core_stepdown_a_summary;
  assign summary_d[`GEVSF_CORE_B_BIT-`GEVSF_FIELD_LSB] =
    core_stepdown_b_summary;
  assign summary_d[`GEVSF_AUX_BIT-`GEVSF_FIELD_LSB] =
    aux_stepdown_summary;

  // Linear regulator bits.
  assign summary_d[`GEVSF_LIN_A_BIT-`GEVSF_FIELD_LSB] =
    linear_reg_a_summary;
  assign summary_d[`GEVSF_LIN_B_BIT-`GEVSF_FIELD_LSB] =
    linear_reg_b_summary;
  assign summary_d[`GEVSF_LIN_C_BIT-`GEVSF_FIELD_LSB] =
    linear_reg_c_summary;
  assign summary_d[`GEVSF_HV_LIN_BIT-`GEVSF_FIELD_LSB] =
    hv_linear_reg_summary;

  // Timer, supply and thermal self-test bits.
  assign summary_d[`GEVSF_STBY_TMR_BIT-`GEVSF_FIELD_LSB] =
    standby_timer_summary;
  assign summary_d[`GEVSF_SUPPLY_UV_BIT-`GEVSF_FIELD_LSB] =
    supply_uv_summary;
  assign summary_d[`GEVSF_THERM_ST_BIT-`GEVSF_FIELD_LSB] =
    thermal_selftest_summary;

  // Address decode; only the main page location zero belongs here. Page
  // and address are compared in full, so the summary has no alias on the
  // other page or at any other location.
  assign reg_hit = (reg_page == `GEVSF_PAGE_MAIN) &&
    (reg_addr == `GEVSF_SUMMARY_ADDR);
  assign rd_hit = reg_rd & reg_hit;
  assign wr_hit = reg_wr & reg_hit;

  // The live copy is refreshed every cycle and never latches an event,
  // so a bit falls one cycle after its last source clears.
  // Nothing here can hold a bit up once its group is quiet.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      summary_q <= `GEVSF_SUMMARY_RESET;
    end else begin
      summary_q <= summary_d;
    end
  end

  // The read answer strobe stands for exactly one cycle after each read hit,
  // so a host that issues reads back to back sees it held high, one cycle per read, with no gap between.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= rd_hit;
    end
  end

  // A read samples the summary straight from the flags rather than from
  // summary_q, which saves one cycle of staleness on a confirm read.
  // The word then stands until the next read hit, so a slow host may pick it
  // up at leisure; misses and writes leave it alone.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= `GEVSF_SUMMARY_RESET;
    end else if (rd_hit) begin
      reg_rdata_q <= summary_d;
    end
  end

  // Writes change nothing; they are only reported, and no flag input is
  // touched because this block has no path back to the flag registers.
  // A write that comes with a read in the same cycle is reported here all
  // the same, while the read path answers the read as usual.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_ignored_q <= 1'b0;
    end else begin
      reg_wr_ignored_q <= wr_hit;
    end
  end

endmodule // gevsf_summary_reg

//--- bench/gevsf_summary_reg_assertions.sv
`timescale 1ns/1ps
// Flags pass one register stage, so each bit trails its cause by one edge.
module gevsf_summary_reg_assertions (
  // Clock, reset and strobes.
  input logic clk,
  input logic rst_n,
  input logic reg_page,
  input logic [5:0] reg_addr,
  input logic reg_rd,
  input logic reg_wr,
  // Watched flags.
  input logic die_temp_event_flag,
  input logic bias_reg_uv_high_flag,
  input logic comm_crc_err_flag,
  input logic comm_req_err_flag,
  input logic wake_input_a,
  input logic wake_input_b,
  input logic thermal_selftest_error_flag,
  // Answers.
  input logic [15:0] reg_rdata_q,
  input logic reg_rvalid_q,
  input logic reg_wr_ignored_q,
  input logic [15:0] summary_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Only the main page at address zero is a hit.
  logic hit;
  assign hit = !reg_page && reg_addr == 6'h00;
  chk_die_temp_bit: assert property ($past(rst_n) |->
    summary_q[15] == $past(die_temp_event_flag)) else $error("bit 23");
  chk_bias_uv_bit: assert property ($past(rst_n) |->
    summary_q[14] == $past(bias_reg_uv_high_flag)) else $error("bit 22");
  chk_comm_err_bit: assert property ($past(rst_n) |-> summary_q[13] ==
    ($past(comm_crc_err_flag) | $past(comm_req_err_flag))) else $error("b21");
  chk_wake_any_bit: assert property ($past(rst_n) |-> summary_q[12] ==
    ($past(wake_input_a) | $past(wake_input_b))) else $error("bit 20");
  chk_selftest_bit: assert property ($past(rst_n) |->
    summary_q[0] == $past(thermal_selftest_error_flag)) else $error("bit 8");
  chk_read_answer: assert property (reg_rd && hit |=>
    reg_rvalid_q && reg_rdata_q == summary_q) else $error("read answer");
  chk_read_cause: assert property (reg_rvalid_q |->
    $past(reg_rd) && $past(hit)) else $error("stray read answer");
  chk_write_dropped: assert property (reg_wr && !reg_rd && hit |=>
    reg_wr_ignored_q && !reg_rvalid_q && $stable(reg_rdata_q))
    else $error("write not dropped");
endmodule // gevsf_summary_reg_assertions

bind gevsf_summary_reg gevsf_summary_reg_assertions
  gevsf_summary_reg_assertions_i (.*);

//--- bench/gevsf_host_model.sv
`timescale 1ns/1ps
// Host side of the register port, one request per call.
module gevsf_host_model (
  // Clock.
  input logic clk,
  // Requests.
  output logic reg_page,
  output logic [5:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  // Answers.
  input logic [15:0] reg_rdata_q,
  input logic reg_rvalid_q,
  input logic reg_wr_ignored_q
);
  initial begin
    reg_page = 1'h1;
    reg_addr = 6'h3F;
    reg_rd = 1'h0;
    reg_wr = 1'h0;
  end
  // Held over one rising edge; lines are scrambled after so stale ones fail.
  task automatic access(input logic rd, wr, pg, input logic [5:0] ad,
      output logic rv, wi, output logic [15:0] dat);
    @(negedge clk);
    reg_page = pg;
    reg_addr = ad;
    reg_rd = rd;
    reg_wr = wr;
    @(negedge clk);
    rv = reg_rvalid_q;
    wi = reg_wr_ignored_q;
    dat = reg_rdata_q;
    reg_rd = 1'h0;
    reg_wr = 1'h0;
    reg_page = ~pg;
    reg_addr = ~ad;
  endtask
endmodule // gevsf_host_model

//--- bench/global_event_summary_flags_bench.sv
`timescale 1ns/1ps
// Drives the flags and plays the host through the host model.
module global_event_summary_flags_bench;
  logic clk;
  logic rst_n;
  logic page, rd, wr, rv, wi, rvw, wiw;
  logic [5:0] addr;
  logic [31:0] f;
  logic [15:0] rdata, summ, dat;
  int bad_count, checks, cyc;
  int st[17] = '{0,1,2,4,6,10,12,14,16,18,20,22,24,27,28,31,32};
  gevsf_summary_reg gevsf_summary_reg_i (.clk(clk), .rst_n(rst_n),
    .reg_page(page), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
    .die_temp_event_flag(f[0]), .bias_reg_uv_high_flag(f[1]),
    .comm_crc_err_flag(f[2]), .comm_req_err_flag(f[3]),
    .wake_input_a(f[4]), .wake_input_b(f[5]),
    .pre_regulator_oc_flag(f[6]), .pre_regulator_uv_high_flag(f[7]),
    .pre_regulator_uv_low_flag(f[8]), .pre_regulator_feedback_ov_flag(f[9]),
    .step_up_ot_flag(f[10]), .step_up_ov_flag(f[11]),
    .core_stepdown_a_oc_flag(f[12]), .core_stepdown_a_ot_flag(f[13]),
    .core_stepdown_b_oc_flag(f[14]), .core_stepdown_b_ot_flag(f[15]),
    .aux_stepdown_oc_flag(f[16]), .aux_stepdown_ot_flag(f[17]),
    .linear_reg_a_oc_flag(f[18]), .linear_reg_a_ot_flag(f[19]),
    .linear_reg_b_oc_flag(f[20]), .linear_reg_b_ot_flag(f[21]),
    .linear_reg_c_oc_flag(f[22]), .linear_reg_c_ot_flag(f[23]),
    .hv_linear_oc_flag(f[24]), .hv_linear_ot_flag(f[25]),
    .hv_linear_input_uv_flag(f[26]), .standby_timer_expiry_flag(f[27]),
    .supply_uv_high_flag(f[28]), .supply_uv_low_flag(f[29]),
    .supply_uv7_flag(f[30]), .thermal_selftest_error_flag(f[31]),
    .reg_rdata_q(rdata), .reg_rvalid_q(rvw), .reg_wr_ignored_q(wiw),
    .summary_q(summ));
  gevsf_host_model gevsf_host_model_i (.clk(clk), .reg_page(page),
    .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_rdata_q(rdata),
    .reg_rvalid_q(rvw), .reg_wr_ignored_q(wiw));
  // Each summary bit is the OR of its flag group; group g lands in bit 15-g.
  function automatic logic [15:0] ex(input logic [31:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int g = 0; g < 16; g++) begin
      for (int i = st[g]; i < st[g+1]; i++) begin
        r[15-g] = r[15-g] | v[i];
      end
    end
    return r;
  endfunction
  task automatic cmp(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic r, w, p, input logic [5:0] a);
    gevsf_host_model_i.access(r, w, p, a, rv, wi, dat);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Each flag alone sets only its bit; the bench clears the flag and the host reads again.
  task automatic scen_each_flag();
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      f = 32'h1 << i;
      @(negedge clk);
      cmp(summ, ex(f));
      req(1'h1, 1'h0, 1'h0, 6'h00);
      cmp(dat, ex(f));
      f = 32'h0;
      req(1'h1, 1'h0, 1'h0, 6'h00);
      cmp(dat, 16'h0000);
    end
  endtask
  // A bit holds while any source of its group remains.
  task automatic scen_partial_clear();
    @(negedge clk);
    f = 32'hFFFF_FFFF;
    @(negedge clk);
    cmp(summ, 16'hFFFF);
    f = 32'h0000_0020;
    @(negedge clk);
    cmp(summ, 16'h1000);
    f = 32'h0;
    @(negedge clk);
    cmp(summ, 16'h0000);
  endtask
  // Writes are dropped; other pages and addresses get no answer.
  task automatic scen_write();
    f = 32'h8421_0C30;
    req(1'h0, 1'h1, 1'h0, 6'h00);
    cmp({14'h0, rv, wi}, 16'h0001);
    cmp(dat, 16'h0000);
    cmp(summ, ex(f));
    req(1'h1, 1'h1, 1'h0, 6'h00);
    cmp({14'h0, rv, wi}, 16'h0003);
    cmp(dat, ex(f));
    req(1'h1, 1'h0, 1'h0, 6'h01);
    cmp({14'h0, rv, wi}, 16'h0000);
    cmp(dat, ex(f));
    req(1'h1, 1'h1, 1'h1, 6'h00);
    cmp({14'h0, rv, wi}, 16'h0000);
    cmp(dat, ex(f));
  endtask
  // A reset in mid-run clears every output even while flags stand, and
  // the summary takes the flags again on the first edge after release.
  task automatic scen_reset();
    f = 32'h0800_0001;
    req(1'h1, 1'h0, 1'h0, 6'h00);
    cmp(dat, 16'h8004);
    rst_n = 1'h0;
    @(negedge clk);
    cmp(summ, 16'h0000);
    cmp(rdata, 16'h0000);
    cmp({14'h0, rvw, wiw}, 16'h0000);
    rst_n = 1'h1;
    @(negedge clk);
    cmp(summ, 16'h8004);
    f = 32'h0;
    req(1'h1, 1'h0, 1'h0, 6'h00);
    cmp({14'h0, rv, wi}, 16'h0002);
    cmp(dat, 16'h0000);
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // A hang is cut short well past the few hundred cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    f = 32'h0;
    rst_n = 1'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'h1;
    req(1'h1, 1'h0, 1'h0, 6'h00);
    cmp({14'h0, rv, wi}, 16'h0002);
    cmp(dat, 16'h0000);
    scen_each_flag();
    scen_partial_clear();
    scen_write();
    scen_reset();
    tally_and_finish();
  end
endmodule // global_event_summary_flags_bench
